/* File: logic/eiop_top.v */
// eight bit io port block: six ports, registers, pin drive and external irq
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "eiop_regs.vh"
//
// How it works
// - pin x uses bit x of its port's data, direction and option registers
// - direction bit clear makes the pin an input
// - direction bit set makes the pin an output driven from the latch
// - data read returns latch for outputs, two-flop synchronised pin level for inputs
// - data writes always update the latch, also for input pins
// - input option 0 floating, 1 pull-up with interrupt
// - output option 0 open-drain, 1 push-pull
// - input-with-interrupt pin raises its vector per the polarity selection
// - enabled pins of one vector are ANDed before edge or level detection
// - output pins never feed an external interrupt
// - a claiming peripheral overrides data, direction and option
// - peripheral output makes the pin an output, driver type from peripheral
// - a claimed pin is an output with the peripheral's driver type, so open-drain releases a high; data read still follows its direction bit
// - data and direction reset to zero, all pins inputs
// - bits of unbonded pins are forced to 1 by hardware
// - polarity pair 00 fall+low, 10 fall, 01 rise, 11 both edges
// - edge requests latch, clear on service entry and on polarity change
// - vectors: a0-3, f0-2, b0-3, b4-7

module eiop_top #(
  parameter [47:0] BONDED_MASK = 48'hffff_ffff_ffff
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  // register port
  input  wire [4:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [7:0]  rdata_o,
  // pins, slot order a,c,b,e,d,f in bytes 0..5
  input  wire [47:0] pin_i,
  output wire [47:0] pin_o,
  output wire [47:0] pin_oe_o,
  output wire [47:0] pullup_o,
  // peripheral alternate functions
  input  wire [47:0] alt_en_i,
  input  wire [47:0] alt_out_i,
  input  wire [47:0] alt_pp_i,
  output wire [47:0] pin_level_o,
  // external interrupts
  input  wire [1:0]  irq_polarity_lo_pair_i,
  input  wire [1:0]  irq_polarity_hi_pair_i,
  input  wire [3:0]  irq_ack_i,
  output wire [3:0]  ext_irq_vector_o
);

  // ************************************************
  // registers
  // ************************************************
  reg  [47:0] data_ff;
  reg  [47:0] dir_ff;
  reg  [47:0] opt_ff;
  reg  [7:0]  rdata_ff;
  reg  [1:0]  pol_lo_ff;
  reg  [1:0]  pol_hi_ff;

  wire [2:0]  slot;
  wire [1:0]  sel;
  wire        slot_ok;
  wire [47:0] sync_lvl;
  reg  [7:0]  nxt_rdata;
  integer     w;
  integer     r;
  genvar      g;

  assign slot    = addr_i[4:2];
  assign sel     = addr_i[1:0];
  assign slot_ok = (slot < `EIOP_NUM_SLOTS);

  // ************************************************
  // pin synchroniser
  // ************************************************
  eiop_sync2 #(
    .W (48)
  ) u_eiop_sync2 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .d_i       (pin_i),
    .q_o       (sync_lvl)
  );

  // unbonded pins read as 1
  wire [47:0] level = sync_lvl | ~BONDED_MASK;
  assign pin_level_o = level;

  // ************************************************
  // register writes
  // ************************************************
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_ff <= {6{`EIOP_DATA_RST}};
      dir_ff  <= {6{`EIOP_DIR_RST}};
      opt_ff  <= {6{`EIOP_OPT_RST}};
    end else begin
      for (w = 0; w < 6; w = w + 1) begin
        if (wr_i && slot_ok && slot == w[2:0]) begin
          if (sel == `EIOP_SEL_DATA)
            data_ff[w*8 +: 8] <= wdata_i;
          if (sel == `EIOP_SEL_DIR)
            dir_ff[w*8 +: 8] <= wdata_i;
          if (sel == `EIOP_SEL_OPT)
            opt_ff[w*8 +: 8] <= wdata_i;
        end
      end
    end
  end

  // stored view with unbonded bits forced high
  wire [47:0] data_v = data_ff | ~BONDED_MASK;
  wire [47:0] dir_v  = dir_ff | ~BONDED_MASK;
  wire [47:0] opt_v  = opt_ff | ~BONDED_MASK;

  // ************************************************
  // register reads
  // ************************************************
  always @* begin
    nxt_rdata = 8'h00;
    for (r = 0; r < 6; r = r + 1) begin
      if (rd_i && slot_ok && slot == r[2:0]) begin
        case (sel)
          `EIOP_SEL_DATA:
            nxt_rdata = (dir_v[r*8 +: 8] & data_v[r*8 +: 8]) |
                        (~dir_v[r*8 +: 8] & level[r*8 +: 8]);
          `EIOP_SEL_DIR:  nxt_rdata = dir_v[r*8 +: 8];
          `EIOP_SEL_OPT:  nxt_rdata = opt_v[r*8 +: 8];
          default:        nxt_rdata = 8'h00;
        endcase
      end
    end
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end
  assign rdata_o = rdata_ff;

  // ************************************************
  // pin drive
  // ************************************************
  // one cell per pin, bit x of each register feeds pin x
  generate
    for (g = 0; g < 48; g = g + 1) begin : g_pin
      eiop_pin_cell #(
        .BONDED (BONDED_MASK[g])
      ) u_eiop_pin_cell (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .dir_i     (dir_ff[g]),
        .opt_i     (opt_ff[g]),
        .data_i    (data_ff[g]),
        .alt_en_i  (alt_en_i[g]),
        .alt_out_i (alt_out_i[g]),
        .alt_pp_i  (alt_pp_i[g]),
        .pin_o     (pin_o[g]),
        .pin_oe_o  (pin_oe_o[g]),
        .pullup_o  (pullup_o[g])
      );
    end
  endgenerate

  // ************************************************
  // external interrupt sources
  // ************************************************
  // input with interrupt: input, option set, not claimed, bonded
  wire [47:0] irq_en = ~dir_ff & opt_ff & ~alt_en_i & BONDED_MASK;
  wire [47:0] gated  = sync_lvl | ~irq_en;
  wire [3:0]  src;
  assign src[0] = &gated[3:0];    // port a pins 0-3
  assign src[1] = &gated[42:40];  // port f pins 0-2
  assign src[2] = &gated[19:16];  // port b pins 0-3
  assign src[3] = &gated[23:20];  // port b pins 4-7

  wire       lo_chg = (irq_polarity_lo_pair_i != pol_lo_ff);
  wire       hi_chg = (irq_polarity_hi_pair_i != pol_hi_ff);

  // ************************************************
  // pending requests
  // ************************************************
  // last polarity codes, kept only to spot a change
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pol_lo_ff <= `EIOP_POL_FALL_LOW;
      pol_hi_ff <= `EIOP_POL_FALL_LOW;
    end else begin
      pol_lo_ff <= irq_polarity_lo_pair_i;
      pol_hi_ff <= irq_polarity_hi_pair_i;
    end
  end

  eiop_irq_det u_eiop_irq_det_0 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .src_i     (src[0]),
    .pol_i     (irq_polarity_lo_pair_i),
    .pol_chg_i (lo_chg),
    .ack_i     (irq_ack_i[0]),
    .req_o     (ext_irq_vector_o[0])
  );

  eiop_irq_det u_eiop_irq_det_1 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .src_i     (src[1]),
    .pol_i     (irq_polarity_lo_pair_i),
    .pol_chg_i (lo_chg),
    .ack_i     (irq_ack_i[1]),
    .req_o     (ext_irq_vector_o[1])
  );

  eiop_irq_det u_eiop_irq_det_2 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .src_i     (src[2]),
    .pol_i     (irq_polarity_hi_pair_i),
    .pol_chg_i (hi_chg),
    .ack_i     (irq_ack_i[2]),
    .req_o     (ext_irq_vector_o[2])
  );

  eiop_irq_det u_eiop_irq_det_3 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .src_i     (src[3]),
    .pol_i     (irq_polarity_hi_pair_i),
    .pol_chg_i (hi_chg),
    .ack_i     (irq_ack_i[3]),
    .req_o     (ext_irq_vector_o[3])
  );

endmodule // eiop_top

// ************************************************
// two flop synchroniser
// ************************************************
module eiop_sync2 #(
  parameter W = 48
) (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         rstn_i,
  // async levels in, synced levels out
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg  [W-1:0] sync1_ff;
  reg  [W-1:0] sync2_ff;

  // only the second flop is read outside
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_ff <= {W{1'b0}};
      sync2_ff <= {W{1'b0}};
    end else begin
      sync1_ff <= d_i;
      sync2_ff <= sync1_ff;
    end
  end
  assign q_o = sync2_ff;
endmodule // eiop_sync2

// ************************************************
// one vector: edge and level detect, pending flag
// ************************************************
module eiop_irq_det (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  // combined source and controls
  input  wire       src_i,
  input  wire [1:0] pol_i,
  input  wire       pol_chg_i,
  input  wire       ack_i,
  // request to the cpu
  output wire       req_o
);
  reg  src_ff;
  reg  pend_ff;
  reg  edge_det;
  reg  low_lvl;

  always @* begin
    edge_det = 1'b0;
    low_lvl  = 1'b0;
    case (pol_i)
      `EIOP_POL_FALL_LOW: begin
        edge_det = src_ff & ~src_i;
        low_lvl  = ~src_i;
      end
      `EIOP_POL_FALL: edge_det = src_ff & ~src_i;
      `EIOP_POL_RISE: edge_det = ~src_ff & src_i;
      `EIOP_POL_BOTH: edge_det = src_ff ^ src_i;
      default:        edge_det = 1'b0;
    endcase
  end

  // source idles high, so no false edge after reset
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_ff  <= 1'b1;
      pend_ff <= 1'b0;
    end else begin
      src_ff  <= src_i;
      // a new edge wins over ack and polarity change
      pend_ff <= (pend_ff & ~ack_i & ~pol_chg_i) | edge_det;
    end
  end

  assign req_o = pend_ff | low_lvl;
endmodule // eiop_irq_det

// ************************************************
// one pin: mode select and pad controls
// ************************************************
module eiop_pin_cell #(
  parameter [0:0] BONDED = 1'b1
) (
  // clock and reset
  input  wire ref_clk_i,
  input  wire rstn_i,
  // port register bits
  input  wire dir_i,
  input  wire opt_i,
  input  wire data_i,
  // peripheral alternate function
  input  wire alt_en_i,
  input  wire alt_out_i,
  input  wire alt_pp_i,
  // pad controls
  output wire pin_o,
  output wire pin_oe_o,
  output wire pullup_o
);
  // alternate function wins over port registers
  wire eff_out = alt_en_i | dir_i;
  wire eff_val = alt_en_i ? alt_out_i : data_i;
  wire eff_pp  = alt_en_i ? alt_pp_i : opt_i;
  reg  pin_ff;
  reg  oe_ff;
  reg  pull_ff;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_ff  <= 1'b0;
      oe_ff   <= 1'b0;
      pull_ff <= 1'b0;
    end else begin
      pin_ff  <= eff_val;
      // open drain drives only the low level
      oe_ff   <= eff_out & (eff_pp | ~eff_val) & BONDED;
      pull_ff <= ~eff_out & opt_i & BONDED;
    end
  end
  assign pin_o    = pin_ff;
  assign pin_oe_o = oe_ff;
  assign pullup_o = pull_ff;
endmodule // eiop_pin_cell

/* File: logic/eiop_regs.vh */
// register offsets, field codes and reset values of the io port block
`ifndef EIOP_REGS_VH
`define EIOP_REGS_VH

// port slots in address order: a, c, b, e, d, f
`define EIOP_PORT_A_DATA      5'h00
`define EIOP_PORT_A_DIRECTION 5'h01
`define EIOP_PORT_A_OPTION    5'h02
`define EIOP_PORT_C_DATA      5'h04
`define EIOP_PORT_C_DIRECTION 5'h05
`define EIOP_PORT_C_OPTION    5'h06
`define EIOP_PORT_B_DATA      5'h08
`define EIOP_PORT_B_DIRECTION 5'h09
`define EIOP_PORT_B_OPTION    5'h0a
`define EIOP_PORT_E_DATA      5'h0c
`define EIOP_PORT_E_DIRECTION 5'h0d
`define EIOP_PORT_E_OPTION    5'h0e
`define EIOP_PORT_D_DATA      5'h10
`define EIOP_PORT_D_DIRECTION 5'h11
`define EIOP_PORT_D_OPTION    5'h12
`define EIOP_PORT_F_DATA      5'h14
`define EIOP_PORT_F_DIRECTION 5'h15
`define EIOP_PORT_F_OPTION    5'h16

// low two address bits select the register inside a slot
`define EIOP_SEL_DATA   2'h0
`define EIOP_SEL_DIR    2'h1
`define EIOP_SEL_OPT    2'h2
`define EIOP_NUM_SLOTS  3'h6

`define EIOP_DATA_RST   8'h00
`define EIOP_DIR_RST    8'h00
`define EIOP_OPT_RST    8'h00

// polarity pair codes {hi, lo}
`define EIOP_POL_FALL_LOW 2'h0
`define EIOP_POL_RISE     2'h1
`define EIOP_POL_FALL     2'h2
`define EIOP_POL_BOTH     2'h3

`endif

/* File: bench/eiop_top_asserts.sv */
// assertions on the io port block ports
`timescale 1ns/100ps
module eiop_chk (
  // clock, reset, register read
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [4:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // pins and peripherals
  input wire logic [47:0] pin_i,
  input wire logic [47:0] pin_o,
  input wire logic [47:0] pin_oe_o,
  input wire logic [47:0] pullup_o,
  input wire logic [47:0] pin_level_o,
  input wire logic [47:0] alt_en_i,
  input wire logic [47:0] alt_out_i,
  input wire logic [47:0] alt_pp_i,
  input wire logic [3:0]  ext_irq_vector_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  rd_idle_a: assert property (!$past(rd_i) |-> !rdata_o)
    else $error("read data idle");
  rd_unmap_a: assert property (rd_i && (&addr_i[1:0] || addr_i > 5'h17) |=> !rdata_o)
    else $error("unmapped read");
  rst_out_a: assert property ($rose(rstn_i) |-> !pin_oe_o && !pullup_o && !ext_irq_vector_o)
    else $error("reset outputs");
  rst_lvl_a: assert property ($rose(rstn_i) |-> !rdata_o && !pin_level_o)
    else $error("reset levels");
  alt_pp_a: assert property (alt_en_i[0] && alt_pp_i[0]
    |=> pin_oe_o[0] && pin_o[0] == $past(alt_out_i[0])) else $error("alt push-pull");
  alt_od_a: assert property (alt_en_i[9] && !alt_pp_i[9]
    |=> pin_oe_o[9] == !$past(alt_out_i[9])) else $error("alt open-drain");
  pull_drv_a: assert property (!(pullup_o & pin_oe_o)) else $error("pull-up on driver");
  sync_lvl_a: assert property (rstn_i [*3] |-> pin_level_o == $past(pin_i, 2))
    else $error("pin level sync");
endmodule // eiop_chk
bind eiop_top eiop_chk u_eiop_chk (
  .ref_clk_i        (ref_clk_i),
  .rstn_i           (rstn_i),
  .addr_i           (addr_i),
  .rd_i             (rd_i),
  .rdata_o          (rdata_o),
  .pin_i            (pin_i),
  .pin_o            (pin_o),
  .pin_oe_o         (pin_oe_o),
  .pullup_o         (pullup_o),
  .pin_level_o      (pin_level_o),
  .alt_en_i         (alt_en_i),
  .alt_out_i        (alt_out_i),
  .alt_pp_i         (alt_pp_i),
  .ext_irq_vector_o (ext_irq_vector_o)
);

/* File: bench/eiop_pin_model.sv */
// pin side model: external drivers, pull-ups, floating pins
`timescale 1ns/100ps
module eiop_pin_model (
  // clock and pins
  input  wire logic        ref_clk_i,
  input  wire logic [47:0] pin_o,
  input  wire logic [47:0] pin_oe_o,
  input  wire logic [47:0] pullup_o,
  // external drive
  input  wire logic [47:0] ext_en_i,
  input  wire logic [47:0] ext_val_i,
  output wire logic [47:0] pin_i
);
  logic [47:0] flt_ff = 48'h0;
  // undriven floating pins wander
  always @(negedge ref_clk_i) flt_ff <= ~flt_ff;
  assign pin_i = pin_oe_o & pin_o | ~pin_oe_o & (ext_en_i & ext_val_i
    | ~ext_en_i & (pullup_o | flt_ff));
endmodule // eiop_pin_model

/* File: bench/test_eight_bit_io_port.sv */
// self-checking bench of the io port block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_eight_bit_io_port;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [4:0]  addr_i    = 5'h00;
  logic [7:0]  wdata_i   = 8'h00;
  logic [1:0]  irq_polarity_lo_pair_i = 2'h0;
  logic [1:0]  irq_polarity_hi_pair_i = 2'h0;
  logic [3:0]  irq_ack_i = 4'h0;
  logic [47:0] alt_en_i  = 48'h0;
  logic [47:0] alt_out_i = 48'h0;
  logic [47:0] alt_pp_i  = 48'h0;
  logic [47:0] ext_en_i  = ~48'h0;
  logic [47:0] ext_val_i;
  wire  [7:0]  rdata_o;
  wire  [3:0]  ext_irq_vector_o;
  wire  [47:0] pin_i, pin_o, pin_oe_o, pullup_o, pin_level_o;
  logic [7:0]  exp_q[$];
  logic [7:0]  lat, dir, e8;
  logic        rd_d = 1'b0;
  int          errors = 0, n_tests = 0, cyc = 0;
  eiop_top u_eiop_top (.*);
  eiop_pin_model u_eiop_pin_model (.*);
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    rd_d <= rd_i;
    cyc <= cyc + 1;
    if (rd_d) begin
      e8 = exp_q.pop_front();
      `CHK(rdata_o, e8)
    end
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {2'b10, a, v};
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    {wr_i, rd_i, addr_i} <= {2'b01, a};
    exp_q.push_back(e);
  endtask
  task automatic idle(input int n);
    @(posedge ref_clk_i);
    {wr_i, rd_i} <= 2'b00;
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic ack();
    irq_ack_i[0] <= 1'b1;
    @(posedge ref_clk_i);
    irq_ack_i[0] <= 1'b0;
    idle(2);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8ccc));
    ext_val_i = 48'({$urandom, $urandom});
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    idle(2);
    for (int s = 0; s < 6; s++) begin
      rd(5'(4*s), ext_val_i[8*s+:8]);
      rd(5'(4*s+1), 8'h00);
      rd(5'(4*s+2), 8'h00);
      rd(5'(4*s+3), 8'h00);
    end
    rd(5'h18, 8'h00);
    for (int s = 0; s < 6; s++) begin
      lat = 8'($urandom);
      dir = 8'($urandom);
      wr(5'(4*s), lat);
      wr(5'(4*s+2), 8'hff);
      wr(5'(4*s+1), dir);
      idle(4);
      rd(5'(4*s), (lat & dir) | (ext_val_i[8*s+:8] & ~dir));
      idle(0);
      `CHK(pin_oe_o[8*s+:8], dir)
      `CHK(pin_o[8*s+:8] & dir, lat & dir)
      wr(5'(4*s+2), 8'h00);
      idle(1);
      `CHK(pin_oe_o[8*s+:8], dir & ~lat)
      wr(5'(4*s+1), 8'h00);
    end
    ext_en_i[3:0] <= 4'h0;
    wr(5'h02, 8'h0f);
    idle(4);
    `CHK(pullup_o[7:0], 8'h0f)
    rd(5'h00, {ext_val_i[7:4], 4'hf});
    ext_val_i[1] <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      irq_polarity_lo_pair_i <= 2'(c);
      idle(3);
      ext_en_i[1] <= 1'b1;
      idle(5);
      `CHK(ext_irq_vector_o[0], c != 1)
      ack();
      `CHK(ext_irq_vector_o[0], c == 0)
      ext_en_i[1] <= 1'b0;
      idle(5);
      `CHK(ext_irq_vector_o[0], c[0])
      ack();
    end
    ext_val_i[20] <= 1'b1;
    irq_polarity_hi_pair_i <= 2'h2;
    wr(5'h0a, 8'h10);
    idle(4);
    `CHK(ext_irq_vector_o[3], 1'b0)
    ext_val_i[20] <= 1'b0;
    idle(5);
    `CHK(ext_irq_vector_o[3], 1'b1)
    irq_polarity_hi_pair_i <= 2'h3;
    idle(2);
    `CHK(ext_irq_vector_o[3], 1'b0)
    wr(5'h0a, 8'h00);
    wr(5'h02, 8'h00);
    repeat (8) begin
      alt_en_i <= 48'({$urandom, $urandom});
      alt_out_i <= 48'({$urandom, $urandom});
      alt_pp_i <= 48'({$urandom, $urandom});
      idle(2);
      `CHK(pin_oe_o, alt_en_i & (alt_pp_i | ~alt_out_i))
      `CHK(pin_o & pin_oe_o, alt_en_i & alt_pp_i & alt_out_i)
    end
    finish_test();
  end
endmodule // test_eight_bit_io_port
